// ### design/srqe_err_fifo.sv
// Purpose: Oldest-first error queue with overflow marking
// Assumes: Writes and reads are one-cycle pulses on the same clock
// Notes:   A full queue absorbs further errors into its newest entry
`timescale 1ns/1ps
module srqe_err_fifo
	import srqe_pkg::*;
#(
	parameter int DEPTH = SRQE_QUEUE_DEPTH,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_b,
	// Control
	input  wire logic                  i_clear,
	input  wire logic                  i_wr,
	input  wire logic [SRQE_ERR_W-1:0] i_wr_code,
	input  wire logic                  i_rd,
	// Read answer
	output logic      [SRQE_ERR_W-1:0] o_rd_code,
	output logic                       o_rd_valid,
	output logic      [AW:0]           o_count
);

	logic [SRQE_ERR_W-1:0] mem [DEPTH];
	logic [AW-1:0]         wr_ptr;
	logic [AW-1:0]         rd_ptr;
	logic [AW:0]           count;

	localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
	localparam logic [AW-1:0] PTR_ONE = AW'(1);
	localparam logic [AW:0]   CNT_ONE = (AW+1)'(1);

	wire       empty = (count == '0);
	wire       full = (count == FULL_COUNT);
	wire       do_rd = i_rd && !empty;
	// A read in the same cycle frees a slot for a normal write
	wire       do_push = i_wr && (!full || do_rd);
	wire       do_mark = i_wr && full && !do_rd;
	wire [AW-1:0] newest_ptr = (wr_ptr == '0) ? LAST_PTR : wr_ptr - PTR_ONE;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == LAST_PTR) ? '0 : p + PTR_ONE;
	endfunction

	always_ff @(posedge i_sys_clk) begin
		// [R7] Store in arrival order
		if (do_push) begin
			mem[wr_ptr] <= i_wr_code;
		end
		// [R8] Overflow marks newest
		else if (do_mark) begin
			mem[newest_ptr] <= SRQE_CODE_TOO_MANY;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b || i_clear) begin
			// [R9] Clear empties queue
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= ptr_inc(wr_ptr);
			end
			if (do_rd) begin
				rd_ptr <= ptr_inc(rd_ptr);
			end
			if (do_push && !do_rd) begin
				count <= count + CNT_ONE;
			end else if (do_rd && !do_push) begin
				count <= count - CNT_ONE;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_rd_code  <= SRQE_CODE_NONE;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd;
			if (i_rd) begin
				// [R10] Empty reads zero
				o_rd_code <= empty ? SRQE_CODE_NONE : mem[rd_ptr];
			end
		end
	end

	assign o_count = count;

endmodule

// ### design/srqe_err_map.sv
// Purpose: Map an error kind to its queued code
// Assumes: Kind OTHER passes the parser-supplied code through
// Notes:   Purely combinational
`timescale 1ns/1ps
module srqe_err_map
	import srqe_pkg::*;
(
	// Error report
	input  wire srqe_err_kind_t        i_kind,
	input  wire logic [SRQE_ERR_W-1:0] i_code,
	// Mapped code
	output logic      [SRQE_ERR_W-1:0] o_code
);

	always_comb begin
		unique case (i_kind)
			// [R11] Header syntax
			SRQE_ERR_SYNTAX:   o_code = SRQE_CODE_SYNTAX;
			// [R12] Missing parameter
			SRQE_ERR_MISSING:  o_code = SRQE_CODE_MISSING;
			// [R13] Parameter type
			SRQE_ERR_TYPE:     o_code = SRQE_CODE_TYPE;
			// [R14] Numeric invalid
			SRQE_ERR_NUM_INV:  o_code = SRQE_CODE_NUM_INV;
			// [R15] Value overflow
			SRQE_ERR_OVERFLOW: o_code = SRQE_CODE_OVERFLOW;
			// [R16] Negative value
			SRQE_ERR_NEGATIVE: o_code = SRQE_CODE_NEGATIVE;
			SRQE_ERR_OTHER:    o_code = i_code;
			default:           o_code = i_code;
		endcase
	end

endmodule

// ### design/srqe_pkg.sv
// Purpose: Shared constants and types for the service request and error queue
// Assumes: Single 100 MHz clock, synchronous active-low reset
// Notes:   Error codes are 16-bit two's complement values
//
// Behaviour
// [R1] Mask held as two-digit decimal, loaded by set command, returned by get.
// [R2] On each output buffer load, mask ANDed with status bits 1 to 6.
// [R3] Any enabled true status bit sets bit 7, request-service, raising request.
// [R4] Mask 32 enables only any-error bit, so errors raise requests.
// [R5] Mask codes add; 33 enables both error and overrange bits.
// [R6] Power-up and device clear set mask to zero, holding request false.
// [R7] Errors kept in an oldest-first queue holding up to 16 entries.
// [R8] Error while full overwrites newest with -350; later errors dropped.
// [R9] Power loss or clear-status empties queue; reset command leaves it.
// [R10] Reading an empty queue returns +0, meaning no error.
// [R11] Malformed command header queues code -102.
// [R12] Too few parameters queues code -115.
// [R13] Parameter of wrong type queues code -117.
// [R14] Invalid numeric or channel-list value queues code -120.
// [R15] Numeric parameter too large, exponent beyond 43, queues code -124.
// [R16] Negative value where not accepted queues code -125.
// [R17] Bit 1 overrange, 5 data available, 6 any error; error sets bit 5.
// [R18] Request-service clears once all mask-enabled status bits are false.
// [R19] Service request line asserted while request-service flag is true.
// [R20] Whole status byte cleared on each new input command string.
package srqe_pkg;

	// Status byte bit positions (bit n of the byte is index n-1)
	localparam int SRQE_BIT_OVERRANGE = 0;
	localparam int SRQE_BIT_DATA_AVAIL = 4;
	localparam int SRQE_BIT_ANY_ERROR = 5;
	localparam int SRQE_BIT_RQS = 6;
	localparam int SRQE_MASK_W = 6;
	localparam int SRQE_STAT_W = 8;

	localparam logic [SRQE_MASK_W-1:0] SRQE_MASK_RESET = 6'h00;
	localparam logic [SRQE_STAT_W-1:0] SRQE_STAT_RESET = 8'h00;
	// Of bits 1 to 6, hardware only ever sets bits 1, 5 and 6
	localparam logic [SRQE_MASK_W-1:0] SRQE_LIVE_BITS = 6'h31;
	localparam logic [SRQE_MASK_W-1:0] SRQE_TRIG_CLEAR = 6'h11;
	localparam logic [SRQE_MASK_W-1:0] SRQE_CMD_CLEAR = 6'h31;

	// Decimal conversion of the mask
	localparam logic [3:0] SRQE_DEC_TEN = 4'ha;
	localparam logic [3:0] SRQE_DEC_MAX_DIGIT = 4'h9;
	localparam logic [6:0] SRQE_MASK_MAX = 7'h3f;

	// Error queue
	localparam int SRQE_ERR_W = 16;
	localparam int SRQE_QUEUE_DEPTH = 16;
	// -102, -115, -117, -120, -124, -125, -350, +0
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_SYNTAX = 16'hff9a;
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_MISSING = 16'hff8d;
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_TYPE = 16'hff8b;
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_NUM_INV = 16'hff88;
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_OVERFLOW = 16'hff84;
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_NEGATIVE = 16'hff83;
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_TOO_MANY = 16'hfea2;
	localparam logic [SRQE_ERR_W-1:0] SRQE_CODE_NONE = 16'h0000;

	typedef enum logic [2:0] {
		SRQE_ERR_SYNTAX   = 3'h0,
		SRQE_ERR_MISSING  = 3'h1,
		SRQE_ERR_TYPE     = 3'h3,
		SRQE_ERR_NUM_INV  = 3'h2,
		SRQE_ERR_OVERFLOW = 3'h6,
		SRQE_ERR_NEGATIVE = 3'h7,
		SRQE_ERR_OTHER    = 3'h5
	} srqe_err_kind_t;

	// Status events from the instrument, one-cycle pulses
	typedef struct packed {
		logic overrange;
		logic buf_load;
		logic buf_read;
		logic dev_cmd;
		logic trigger;
		logic new_string;
	} srqe_stat_ev_t;

	// Error report from the command parser
	typedef struct packed {
		logic                  valid;
		srqe_err_kind_t        kind;
		logic [SRQE_ERR_W-1:0] code;
	} srqe_err_rep_t;

endpackage

// ### design/srqe_top.sv
// Purpose: Service request logic and error queue of the remote interface
// Assumes: All inputs come from logic on i_sys_clk, so none is synchronised
// Notes:   Reset stands for power-up; the reset command is not wired here
`timescale 1ns/1ps
module srqe_top
	import srqe_pkg::*;
#(
	parameter int DEPTH = SRQE_QUEUE_DEPTH
) (
	// Clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_b,
	// Mask commands, value as two decimal digits
	input  wire logic                  i_set_request_mask_command,
	input  wire logic [3:0]            i_mask_tens,
	input  wire logic [3:0]            i_mask_ones,
	input  wire logic                  i_get_request_mask_command,
	input  wire logic                  i_device_clear,
	// Status events
	input  wire srqe_stat_ev_t         i_stat_ev,
	// Error queue access
	input  wire srqe_err_rep_t         i_err,
	input  wire logic                  i_err_read,
	input  wire logic                  i_clear_status,
	// Mask readback
	output logic      [3:0]            o_mask_tens,
	output logic      [3:0]            o_mask_ones,
	output logic                       o_mask_valid,
	// Serial poll byte and bus service request
	output logic      [SRQE_STAT_W-1:0] o_status_byte,
	output logic                       o_srq,
	// Error queue answer
	output logic      [SRQE_ERR_W-1:0] o_err_code,
	output logic                       o_err_valid,
	output logic      [$clog2(DEPTH):0] o_err_count
);

	logic [SRQE_MASK_W-1:0] service_request_enable_mask;
	logic [SRQE_MASK_W-1:0] stat_low;
	logic                   request_service_flag;

	// Decimal to binary; values above 63 would not fit six bits
	function automatic logic [6:0] dec_to_bin(input logic [3:0] tens,
			input logic [3:0] ones);
		logic [7:0] prod;
		prod = {4'h0, tens} * {4'h0, SRQE_DEC_TEN};
		dec_to_bin = 7'(prod) + {3'h0, ones};
	endfunction

	function automatic logic [7:0] bin_to_dec(input logic [5:0] v);
		logic [5:0] t;
		logic [5:0] o;
		t = 6'(v / 6'(SRQE_DEC_TEN));
		o = 6'(v % 6'(SRQE_DEC_TEN));
		bin_to_dec = {t[3:0], o[3:0]};
	endfunction

	// Mask write decode
	wire [6:0] mask_in = dec_to_bin(i_mask_tens, i_mask_ones);
	wire       digits_ok = (i_mask_tens <= SRQE_DEC_MAX_DIGIT) &&
			(i_mask_ones <= SRQE_DEC_MAX_DIGIT) &&
			(mask_in <= SRQE_MASK_MAX);
	wire       mask_wr = i_set_request_mask_command && digits_ok;
	wire [SRQE_MASK_W-1:0] next_mask =
			i_device_clear ? SRQE_MASK_RESET :
			mask_wr        ? mask_in[SRQE_MASK_W-1:0] :
			service_request_enable_mask;
	wire [7:0] mask_dec = bin_to_dec(service_request_enable_mask);

	// [R1] Mask load and clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			// [R6] Power-up mask zero
			service_request_enable_mask <= SRQE_MASK_RESET;
		end else begin
			service_request_enable_mask <= next_mask;
		end
	end

	// [R1] Mask readback
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_mask_tens  <= 4'h0;
			o_mask_ones  <= 4'h0;
			o_mask_valid <= 1'b0;
		end else begin
			o_mask_valid <= i_get_request_mask_command;
			if (i_get_request_mask_command) begin
				o_mask_tens <= mask_dec[7:4];
				o_mask_ones <= mask_dec[3:0];
			end
		end
	end

	// An error loads an error message, so it counts as a buffer load
	wire err_ev = i_err.valid;
	wire buf_loaded = i_stat_ev.buf_load || err_ev;

	// [R17] Status bit sets; error also sets data available
	wire [SRQE_MASK_W-1:0] stat_set =
			({SRQE_MASK_W{i_stat_ev.overrange}} &
			 (6'h01 << SRQE_BIT_OVERRANGE)) |
			({SRQE_MASK_W{buf_loaded}} & (6'h01 << SRQE_BIT_DATA_AVAIL)) |
			({SRQE_MASK_W{err_ev}} & (6'h01 << SRQE_BIT_ANY_ERROR));

	// [R20] New string clears all
	wire [SRQE_MASK_W-1:0] stat_clr =
			({SRQE_MASK_W{i_stat_ev.new_string}} & SRQE_LIVE_BITS) |
			({SRQE_MASK_W{i_stat_ev.dev_cmd || i_stat_ev.buf_read}} &
			 SRQE_CMD_CLEAR) |
			({SRQE_MASK_W{i_stat_ev.trigger}} & SRQE_TRIG_CLEAR);

	// Set wins so an event in a clearing cycle is kept
	wire [SRQE_MASK_W-1:0] next_stat =
			((stat_low & ~stat_clr) | stat_set) & SRQE_LIVE_BITS;

	// [R2] Mask AND status bits
	wire [SRQE_MASK_W-1:0] enabled_bits = next_mask & next_stat;
	wire                   any_enabled = |enabled_bits;

	// [R3] Set on load; [R18] clear when none enabled
	wire next_rqs = (buf_loaded && any_enabled) ||
			(request_service_flag && any_enabled);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			stat_low             <= SRQE_STAT_RESET[SRQE_MASK_W-1:0];
			request_service_flag <= 1'b0;
			o_status_byte        <= SRQE_STAT_RESET;
			o_srq                <= 1'b0;
		end else begin
			stat_low             <= next_stat;
			request_service_flag <= next_rqs;
			o_status_byte        <= {1'b0, next_rqs, next_stat};
			// [R19] Drive service request
			o_srq                <= next_rqs;
		end
	end

	wire [SRQE_ERR_W-1:0] mapped_code;

	srqe_err_map u_err_map (
		.i_kind (i_err.kind),
		.i_code (i_err.code),
		.o_code (mapped_code)
	);

	srqe_err_fifo #(
		.DEPTH (DEPTH)
	) u_err_fifo (
		.i_sys_clk  (i_sys_clk),
		.i_rst_b    (i_rst_b),
		.i_clear    (i_clear_status),
		.i_wr       (err_ev),
		.i_wr_code  (mapped_code),
		.i_rd       (i_err_read),
		.o_rd_code  (o_err_code),
		.o_rd_valid (o_err_valid),
		.o_count    (o_err_count)
	);

endmodule

// ### verification/srqe_ctl_model.sv
// Purpose: Controller side forming mask digits from a summed code
// Assumes: Value within 0 to 63
// Notes:   Combinational; codes are added before conversion
`timescale 1ns/1ps
module srqe_ctl_model (
	// Summed mask code
	input  wire logic [6:0] i_value,
	// Decimal digits
	output logic      [3:0] o_tens,
	output logic      [3:0] o_ones
);
	assign o_tens = 4'(i_value / 7'h0a);
	assign o_ones = 4'(i_value % 7'h0a);
endmodule

// ### verification/srqe_top_properties.sv
// Purpose: Port-level properties of the service request and error queue
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to srqe_top below the module
`timescale 1ns/1ps
module srqe_props
	import srqe_pkg::*;
#(
	parameter int DEPTH = SRQE_QUEUE_DEPTH
) (
	// Clock and reset
	input wire logic                    i_sys_clk,
	input wire logic                    i_rst_b,
	// Requests
	input wire logic                    i_get_request_mask_command,
	input wire logic                    i_device_clear,
	input wire srqe_stat_ev_t           i_stat_ev,
	input wire srqe_err_rep_t           i_err,
	input wire logic                    i_err_read,
	input wire logic                    i_clear_status,
	// Answers
	input wire logic                    o_mask_valid,
	input wire logic [SRQE_STAT_W-1:0]  o_status_byte,
	input wire logic                    o_srq,
	input wire logic [SRQE_ERR_W-1:0]   o_err_code,
	input wire logic                    o_err_valid,
	input wire logic [$clog2(DEPTH):0]  o_err_count
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	AST_GET_ANSWER: assert property (i_get_request_mask_command |=> o_mask_valid)
		else $error("mask readback missing");
	AST_RISE_CAUSE: assert property ($rose(o_srq) |->
		$past(i_stat_ev.buf_load) || $past(i_err.valid))
		else $error("request raised without a buffer load");
	AST_DEV_CLEAR: assert property (i_device_clear |=> !o_srq)
		else $error("request survives device clear");
	AST_FILL_MAX: assert property (o_err_count <= DEPTH)
		else $error("queue fill above depth");
	AST_FULL_HOLD: assert property (i_err.valid && !i_err_read && !i_clear_status
		&& o_err_count == DEPTH |=> o_err_count == DEPTH)
		else $error("full queue fill changed");
	AST_CLEAR_STAT: assert property (i_clear_status |=> o_err_count == 0)
		else $error("queue not emptied");
	AST_EMPTY_READ: assert property (i_err_read && o_err_count == 0 && !i_err.valid
		&& !i_clear_status |=> o_err_valid && o_err_code == 16'h0000)
		else $error("empty read not zero");
	AST_ZERO_BITS: assert property ((o_status_byte & 8'h8e) == 8'h00)
		else $error("unused status bit set");
	AST_ERR_BITS: assert property (i_err.valid |=> o_status_byte[5:4] == 2'h3)
		else $error("error did not set status bits");
	AST_RQS_NEEDS: assert property (o_srq |-> o_status_byte[5:0] != 6'h00)
		else $error("request with no status bit");
	AST_SRQ_LINE: assert property (o_srq == o_status_byte[6])
		else $error("request line differs from flag");

	cover property ($rose(o_srq));
	cover property (o_err_count == DEPTH);
	cover property (o_err_valid && o_err_code == 16'hfea2);
endmodule

bind srqe_top srqe_props #(.DEPTH(DEPTH)) u_props (.i_sys_clk, .i_rst_b,
	.i_get_request_mask_command, .i_device_clear, .i_stat_ev, .i_err,
	.i_err_read, .i_clear_status, .o_mask_valid, .o_status_byte, .o_srq,
	.o_err_code, .o_err_valid, .o_err_count);

// ### verification/tb.sv
// Purpose: Self-checking bench for the service request and error queue
// Assumes: Fixed output latency of one cycle
// Notes:   Queue shortened to four entries to reach overflow quickly
`timescale 1ns/1ps
module tb;
	import srqe_pkg::*;
	localparam int DEPTH = 4;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic set_c = 1'b0, get_c = 1'b0, dclr = 1'b0, rd = 1'b0, cls = 1'b0;
	logic [6:0] mval = 7'h00;
	logic [3:0] tens, ones, m_t, m_o;
	srqe_stat_ev_t ev = '0;
	srqe_err_rep_t er = '0;
	logic [7:0] sb;
	logic srq, mv, e_v;
	logic [15:0] ecode, c;
	logic [2:0] cnt;
	int err_total = 0, comparisons = 0, v, k;
	logic [15:0] q[$];
	srqe_err_kind_t kinds[7] = '{SRQE_ERR_SYNTAX, SRQE_ERR_MISSING,
		SRQE_ERR_TYPE, SRQE_ERR_NUM_INV, SRQE_ERR_OVERFLOW,
		SRQE_ERR_NEGATIVE, SRQE_ERR_OTHER};

	always #5 i_sys_clk = ~i_sys_clk;

	srqe_ctl_model u_ctl (.i_value(mval), .o_tens(tens), .o_ones(ones));
	srqe_top #(.DEPTH(DEPTH)) u_dut (.i_sys_clk, .i_rst_b,
		.i_set_request_mask_command(set_c), .i_mask_tens(tens),
		.i_mask_ones(ones), .i_get_request_mask_command(get_c),
		.i_device_clear(dclr), .i_stat_ev(ev), .i_err(er),
		.i_err_read(rd), .i_clear_status(cls), .o_mask_tens(m_t),
		.o_mask_ones(m_o), .o_mask_valid(mv), .o_status_byte(sb),
		.o_srq(srq), .o_err_code(ecode), .o_err_valid(e_v),
		.o_err_count(cnt));

	task automatic tick();
		@(posedge i_sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pulse_ev(input srqe_stat_ev_t e);
		ev = e;
		tick();
		ev = '0;
	endtask
	task automatic set_mask(input int val);
		mval = 7'(val);
		set_c = 1'b1;
		tick();
		set_c = 1'b0;
	endtask
	task automatic get_chk(input int val);
		get_c = 1'b1;
		tick();
		get_c = 1'b0;
		chk({7'h00, mv, m_t, m_o}, {7'h00, 1'b1, 4'(val / 10), 4'(val % 10)});
	endtask
	task automatic wr_err(input srqe_err_kind_t kd, input logic [15:0] cd);
		er = '{1'b1, kd, cd};
		tick();
		er = '0;
	endtask
	task automatic rd_chk(input logic [15:0] exp);
		rd = 1'b1;
		tick();
		rd = 1'b0;
		chk(ecode, exp);
	endtask
	function automatic logic [15:0] exp_code(input srqe_err_kind_t kd,
		input logic [15:0] cd);
		case (kd)
			SRQE_ERR_SYNTAX: return 16'(-102);
			SRQE_ERR_MISSING: return 16'(-115);
			SRQE_ERR_TYPE: return 16'(-117);
			SRQE_ERR_NUM_INV: return 16'(-120);
			SRQE_ERR_OVERFLOW: return 16'(-124);
			SRQE_ERR_NEGATIVE: return 16'(-125);
			default: return cd;
		endcase
	endfunction
	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h3a7cd599));
		repeat (3) tick();
		i_rst_b = 1'b1;
		chk(16'(sb), 16'h0000);
		get_chk(0);
		$display("reset test done");
		// Both ends of the code range first, then random codes
		for (int i = 0; i < 10; i++) begin
			v = (i < 2) ? i * 63 : int'($urandom_range(63));
			set_mask(v);
			get_chk(v);
		end
		$display("mask test done");
		set_mask(32);
		pulse_ev(6'h20);
		pulse_ev(6'h10);
		chk(16'(srq), 16'h0000);
		chk(16'(sb), 16'h0011);
		wr_err(SRQE_ERR_SYNTAX, 16'h0000);
		chk(16'(sb), 16'h0071);
		pulse_ev(6'h08);
		chk(16'(sb), 16'h0000);
		rd_chk(16'(-102));
		set_mask(32 + 1);
		pulse_ev(6'h20);
		chk(16'(srq), 16'h0000);
		pulse_ev(6'h10);
		chk(16'(sb), 16'h0051);
		pulse_ev(6'h01);
		chk(16'(sb), 16'h0000);
		dclr = 1'b1;
		tick();
		dclr = 1'b0;
		wr_err(SRQE_ERR_TYPE, 16'h0000);
		chk(16'(srq), 16'h0000);
		rd_chk(16'(-117));
		$display("request test done");
		foreach (kinds[i]) begin
			c = 16'($urandom);
			wr_err(kinds[i], c);
			rd_chk(exp_code(kinds[i], c));
		end
		$display("code test done");
		// One write past full so the newest slot is overwritten
		for (int i = 0; i <= DEPTH; i++) begin
			k = int'($urandom_range(6));
			c = 16'($urandom);
			wr_err(kinds[k], c);
			q.push_back(exp_code(kinds[k], c));
		end
		q[DEPTH - 1] = 16'(-350);
		chk(16'(cnt), 16'(DEPTH));
		for (int i = 0; i < DEPTH; i++)
			rd_chk(q[i]);
		rd_chk(16'h0000);
		$display("overflow test done");
		wr_err(SRQE_ERR_MISSING, 16'h0000);
		wr_err(SRQE_ERR_NEGATIVE, 16'h0000);
		cls = 1'b1;
		tick();
		cls = 1'b0;
		chk(16'(cnt), 16'h0000);
		rd_chk(16'h0000);
		$display("clear test done");
		tally_and_finish();
	end
endmodule
